/* hdl/status_sentence_port.v */
// Status-sentence framer: builds ASCII sentences from live measurements
// and sent CAN frames, and streams them byte by byte.
// Assumes a byte sink with valid/ready handshake (a UART or USB bridge)
// and a single clock shared with the AXI4-Lite register master.
`timescale 1ns/100ps
`include "status_sentence_consts.vh"
`default_nettype none

module status_sentence_port #(
    parameter MS_CYCLES = `CLK_HZ / `TICK_HZ
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write
    input wire [7:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // AXI4-Lite read
    input wire [7:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Requests and commands decoded from the receive side
    input wire req_valid,
    input wire [2:0] req_kind,
    input wire restore_req,
    output reg defaults_pulse,
    input wire sleep_mode,
    // Sent CAN frame
    input wire can_tx_valid,
    input wire [1:0] can_tx_class,
    input wire [31:0] can_tx_id,
    input wire can_tx_ext,
    input wire can_tx_rtr,
    input wire [3:0] can_tx_len,
    input wire [63:0] can_tx_data,
    // Charger values
    input wire [7:0] chg_count,
    input wire chg_is_can,
    input wire [7:0] chg_status,
    input wire [15:0] chg_set_v,
    input wire [15:0] chg_set_i,
    input wire chg_act_v_ok,
    input wire [15:0] chg_act_v,
    input wire chg_act_i_ok,
    input wire [15:0] chg_act_i,
    // Pack values
    input wire [31:0] pack_voltage,
    input wire [15:0] pack_current,
    // Distance and energy fields 1..12, field 1 in the low word
    input wire [383:0] dist_fields,
    // Input pins
    input wire mains_presence_input,
    input wire ignition_input,
    input wire rapid_charge_input,
    // Byte stream out
    output reg [7:0] tx_byte,
    output reg tx_valid,
    input wire tx_ready
);

    localparam ST_IDLE = 3'd0;
    localparam ST_TAG = 3'd1;
    localparam ST_SEP = 3'd2;
    localparam ST_FLD = 3'd3;
    localparam ST_CSEP = 3'd4;
    localparam ST_CSHI = 3'd5;
    localparam ST_CSLO = 3'd6;
    localparam ST_EOL = 3'd7;

    // ------------------------------------------------------------------
    // Configuration and status registers
    // ------------------------------------------------------------------
    reg [1:0] ctrl_ff;
    reg [15:0] act_per_ff;
    reg [15:0] slp_per_ff;
    reg [15:0] drops_ff;
    reg [4:0] pend_ff;
    reg [2:0] st_ff;
    reg [2:0] kind_ff;
    reg [3:0] fidx_ff;
    reg [4:0] nib_ff;
    reg [1:0] tidx_ff;
    reg [7:0] sum_ff;
    reg [31:0] can_id_ff;
    reg can_ext_ff;
    reg can_rtr_ff;
    reg [3:0] can_len_ff;
    reg [63:0] can_data_ff;
    reg [15:0] ms_div_ff;
    reg [15:0] per_cnt_ff;

    wire wr_go = awvalid && wvalid && !bvalid && !awready;
    wire rd_go = arvalid && !rvalid && !arready;
    wire busy = (st_ff != ST_IDLE);
    wire [31:0] status_word = {25'h0, sleep_mode, pend_ff, busy};

    // Byte-lane merge for a register write
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] d;
        input [3:0] s;
        begin
            merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    // Write channel: address and data taken together, one at a time
    always @(posedge aclk) begin
        if (!aresetn || restore_req) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            ctrl_ff <= `CTRL_RESET;
            act_per_ff <= `ACTIVE_PERIOD_RESET;
            slp_per_ff <= `SLEEP_PERIOD_RESET;
        end else begin
            awready <= wr_go;
            wready <= wr_go;
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= `RESP_OKAY;
                if (awaddr == `REG_CTRL) begin
                    if (wstrb[0]) begin
                        ctrl_ff <= wdata[1:0];
                    end
                end else if (awaddr == `REG_ACTIVE_PERIOD) begin
                    act_per_ff <= merge16(act_per_ff, wdata, wstrb);
                end else if (awaddr == `REG_SLEEP_PERIOD) begin
                    slp_per_ff <= merge16(slp_per_ff, wdata, wstrb);
                end else if (awaddr == `REG_STATUS || awaddr == `REG_DROPS) begin
                    bresp <= `RESP_OKAY; // Read-only, write ignored
                end else begin
                    bresp <= `RESP_SLVERR;
                end
            end
        end
    end

    // Read channel: data valid in the same cycle the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `RESP_OKAY;
        end else begin
            arready <= rd_go;
            if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
            if (rd_go) begin
                rvalid <= 1'b1;
                rresp <= `RESP_OKAY;
                if (araddr == `REG_CTRL) begin
                    rdata <= {30'h0, ctrl_ff};
                end else if (araddr == `REG_ACTIVE_PERIOD) begin
                    rdata <= {16'h0, act_per_ff};
                end else if (araddr == `REG_SLEEP_PERIOD) begin
                    rdata <= {16'h0, slp_per_ff};
                end else if (araddr == `REG_STATUS) begin
                    rdata <= status_word;
                end else if (araddr == `REG_DROPS) begin
                    rdata <= {16'h0, drops_ff};
                end else begin
                    rdata <= 32'h0;
                    rresp <= `RESP_SLVERR;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Periodic scheduler
    // ------------------------------------------------------------------
    // Millisecond tick; the period register counts ticks
    wire ms_tick = (ms_div_ff == MS_CYCLES[15:0] - 16'd1);
    wire [15:0] period = sleep_mode ? slp_per_ff : act_per_ff;
    wire period_hit = ms_tick && ctrl_ff[`CTRL_PERIODIC_BIT] &&
                      (period != 16'h0) && (per_cnt_ff >= period - 16'd1);

    always @(posedge aclk) begin
        if (!aresetn) begin
            ms_div_ff <= 16'h0;
            per_cnt_ff <= 16'h0;
        end else begin
            ms_div_ff <= ms_tick ? 16'h0 : ms_div_ff + 16'd1;
            if (period_hit) begin
                per_cnt_ff <= 16'h0;
            end else if (ms_tick) begin
                per_cnt_ff <= per_cnt_ff + 16'd1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sent CAN frame capture
    // ------------------------------------------------------------------
    // One frame is held; a frame that arrives while one waits or is being
    // sent is counted as dropped, since the serial side is far slower.
    wire can_keep = can_tx_valid && ctrl_ff[`CTRL_FWD_BIT]
                    && (can_tx_class != 2'b00);
    wire can_busy = pend_ff[`KIND_CAN] || (busy && kind_ff == `KIND_CAN);
    wire can_take = can_keep && !can_busy;

    always @(posedge aclk) begin
        if (!aresetn || restore_req) begin
            drops_ff <= 16'h0;
            can_id_ff <= 32'h0;
            can_ext_ff <= 1'b0;
            can_rtr_ff <= 1'b0;
            can_len_ff <= 4'h0;
            can_data_ff <= 64'h0;
        end else begin
            if (can_keep && can_busy && drops_ff != 16'hffff) begin
                drops_ff <= drops_ff + 16'd1;
            end
            if (can_take) begin
                can_id_ff <= can_tx_id;
                can_ext_ff <= can_tx_ext;
                can_rtr_ff <= can_tx_rtr;
                can_len_ff <= (can_tx_len > `CAN_MAX_LEN) ? `CAN_MAX_LEN
                                                          : can_tx_len;
                can_data_ff <= can_tx_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Field table
    // ------------------------------------------------------------------
    reg [63:0] f_val;
    reg [4:0] f_nib;
    reg f_last;
    wire [6:0] can_shift = 7'd64 - {can_len_ff, 3'b000};
    wire [8:0] dist_base = {fidx_ff, 5'b00000};

    always @* begin
        f_val = 64'h0;
        f_nib = `NIB_NONE;
        f_last = 1'b0;
        case (kind_ff)
            `KIND_CHARGER: begin
                f_last = (fidx_ff == `LAST_CHARGER);
                case (fidx_ff)
                    4'd0: begin
                        f_val = {56'h0, chg_count};
                        f_nib = `NIB_BYTE;
                    end
                    4'd1: begin
                        f_val = {56'h0, chg_status};
                        f_nib = chg_is_can ? `NIB_BYTE : `NIB_NONE;
                    end
                    4'd2: begin
                        f_val = {48'h0, chg_set_v};
                        f_nib = chg_is_can ? `NIB_WORD : `NIB_NONE;
                    end
                    4'd3: begin
                        f_val = {48'h0, chg_set_i};
                        f_nib = chg_is_can ? `NIB_WORD : `NIB_NONE;
                    end
                    4'd4: begin
                        f_val = {48'h0, chg_act_v};
                        f_nib = (chg_is_can && chg_act_v_ok) ? `NIB_WORD
                                                             : `NIB_NONE;
                    end
                    default: begin
                        f_val = {48'h0, chg_act_i};
                        f_nib = (chg_is_can && chg_act_i_ok) ? `NIB_WORD
                                                             : `NIB_NONE;
                    end
                endcase
            end
            `KIND_PACK: begin
                f_last = (fidx_ff == `LAST_PACK);
                f_nib = `NIB_WORD; // Diagnostics sent as zero
                if (fidx_ff == 4'd0) begin
                    f_val = {32'h0, pack_voltage};
                    f_nib = `NIB_DWORD;
                end else if (fidx_ff == 4'd1) begin
                    f_val = {48'h0, pack_current};
                end
            end
            `KIND_DIST: begin
                // Speed, distance, consumption, energies, estimates in
                // caller order
                f_last = (fidx_ff == `LAST_DIST);
                f_val = {32'h0, dist_fields[dist_base +: 32]};
                f_nib = (fidx_ff == 4'd0) ? `NIB_WORD : `NIB_DWORD;
            end
            `KIND_PINS: begin
                f_last = (fidx_ff == `LAST_PINS);
                f_nib = `NIB_BYTE;
                if (fidx_ff == 4'd0) begin
                    f_val = {57'h0, rapid_charge_input, ignition_input,
                             mains_presence_input, 4'h0};
                end
            end
            default: begin
                f_last = (fidx_ff == `LAST_CAN);
                case (fidx_ff)
                    4'd0: begin
                        f_val = {32'h0, can_id_ff};
                        f_nib = `NIB_DWORD;
                    end
                    4'd1: begin
                        f_val = {63'h0, can_ext_ff};
                        f_nib = `NIB_FLAG;
                    end
                    4'd2: begin
                        f_val = {63'h0, can_rtr_ff};
                        f_nib = `NIB_FLAG;
                    end
                    4'd3: begin
                        f_val = {60'h0, can_len_ff}; // One decimal digit
                        f_nib = `NIB_FLAG;
                    end
                    default: begin
                        f_val = can_data_ff >> can_shift;
                        f_nib = {can_len_ff, 1'b0};
                    end
                endcase
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sentence emitter
    // ------------------------------------------------------------------
    function [7:0] hex_asc;
        input [3:0] n;
        begin
            hex_asc = (n < 4'd10) ? `ASC_ZERO + {4'h0, n}
                                  : `ASC_ALPHA + {4'h0, n};
        end
    endfunction

    reg [23:0] tag;
    reg [2:0] pick;
    reg [4:0] req_set;
    wire slot = !tx_valid || tx_ready;
    wire [63:0] nib_shifted = f_val >> {nib_ff - 5'd1, 2'b00};
    wire [7:0] tag_chr = tag[{2'd2 - tidx_ff, 3'b000} +: 8];

    always @* begin
        case (kind_ff)
            `KIND_CHARGER: tag = `TAG_CHARGER;
            `KIND_PACK: tag = `TAG_PACK;
            `KIND_DIST: tag = `TAG_DIST;
            `KIND_PINS: tag = `TAG_PINS;
            default: tag = `TAG_CAN;
        endcase
        // CAN reports first, then the lowest numbered status sentence
        if (pend_ff[`KIND_CAN]) begin
            pick = `KIND_CAN;
        end else if (pend_ff[`KIND_CHARGER]) begin
            pick = `KIND_CHARGER;
        end else if (pend_ff[`KIND_PACK]) begin
            pick = `KIND_PACK;
        end else if (pend_ff[`KIND_DIST]) begin
            pick = `KIND_DIST;
        end else begin
            pick = `KIND_PINS;
        end
        // Requests for one of the four status sentences only
        req_set = 5'h0;
        if (req_valid && req_kind < `KIND_CAN) begin
            req_set[req_kind] = 1'b1;
        end
        if (period_hit) begin
            req_set[3:0] = 4'hf;
        end
        if (can_take) begin
            req_set[`KIND_CAN] = 1'b1;
        end
    end

    // Byte sequencer; a new request wins over the clear of its pending bit
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= ST_IDLE;
            kind_ff <= `KIND_CHARGER;
            fidx_ff <= 4'h0;
            nib_ff <= 5'h0;
            tidx_ff <= 2'h0;
            sum_ff <= 8'h0;
            pend_ff <= 5'h0;
            tx_byte <= 8'h0;
            tx_valid <= 1'b0;
            defaults_pulse <= 1'b0;
        end else begin
            defaults_pulse <= restore_req;
            if (slot) begin
                tx_valid <= 1'b0;
                case (st_ff)
                    ST_IDLE: begin
                        if (pend_ff != 5'h0) begin
                            kind_ff <= pick;
                            pend_ff <= (pend_ff & ~(5'h1 << pick)) | req_set;
                            tidx_ff <= 2'h0;
                            sum_ff <= 8'h0;
                            st_ff <= ST_TAG;
                        end
                    end
                    ST_TAG: begin
                        tx_byte <= tag_chr;
                        tx_valid <= 1'b1;
                        sum_ff <= sum_ff + tag_chr;
                        tidx_ff <= tidx_ff + 2'd1;
                        fidx_ff <= 4'h0;
                        if (tidx_ff == 2'd2) begin
                            st_ff <= ST_SEP;
                        end
                    end
                    ST_SEP: begin // Empty fields are a bare comma
                        tx_byte <= `ASC_COMMA;
                        tx_valid <= 1'b1;
                        sum_ff <= sum_ff + `ASC_COMMA;
                        nib_ff <= f_nib;
                        if (f_nib != `NIB_NONE) begin
                            st_ff <= ST_FLD;
                        end else if (f_last) begin
                            st_ff <= ST_CSEP;
                        end else begin
                            fidx_ff <= fidx_ff + 4'd1;
                        end
                    end
                    ST_FLD: begin
                        tx_byte <= hex_asc(nib_shifted[3:0]);
                        tx_valid <= 1'b1;
                        sum_ff <= sum_ff + hex_asc(nib_shifted[3:0]);
                        nib_ff <= nib_ff - 5'd1;
                        if (nib_ff == 5'd1) begin
                            if (f_last) begin
                                st_ff <= ST_CSEP;
                            end else begin
                                fidx_ff <= fidx_ff + 4'd1;
                                st_ff <= ST_SEP;
                            end
                        end
                    end
                    ST_CSEP: begin
                        tx_byte <= `ASC_COMMA;
                        tx_valid <= 1'b1;
                        sum_ff <= sum_ff + `ASC_COMMA;
                        st_ff <= ST_CSHI;
                    end
                    ST_CSHI: begin
                        tx_byte <= hex_asc(sum_ff[7:4]);
                        tx_valid <= 1'b1;
                        st_ff <= ST_CSLO;
                    end
                    ST_CSLO: begin
                        tx_byte <= hex_asc(sum_ff[3:0]);
                        tx_valid <= 1'b1;
                        st_ff <= ST_EOL;
                    end
                    default: begin
                        tx_byte <= `ASC_LF;
                        tx_valid <= 1'b1;
                        st_ff <= ST_IDLE;
                    end
                endcase
                if (st_ff != ST_IDLE || pend_ff == 5'h0) begin
                    pend_ff <= pend_ff | req_set;
                end
            end else begin
                pend_ff <= pend_ff | req_set;
            end
        end
    end

endmodule // status_sentence_port

`default_nettype wire

/* hdl/status_sentence_consts.vh */
// Constants for the status-sentence framer: register map, reset values,
// field layouts, ASCII codes and timing.
// Assumes a single 50 MHz clock and a 32-bit AXI4-Lite register port.
//
// Overview of operation
// - Sent CAN frames are reported only while serial forwarding is enabled.
// - Only charger, own-protocol and peripheral-config frames are reported.
// - Sent-frame report uses the same field layout as the received-frame one.
// - Fields: 4-byte hex id, extended flag, remote flag, decimal length, data.
// - Four status sentences repeat at separate active and sleep intervals.
// - A '?' request for a status sentence makes it be sent at once.
// - Charger: count, status, set V, set I, actual V, actual I in 0.1 units.
// - Non-CAN charger leaves status and set fields empty; missing actuals too.
// - Pack sentence field one is total voltage, unsigned, 0.01 V.
// - Field two is pack current, signed 0.1 A, positive means charging.
// - Pack fields three to ten are reserved diagnostics.
// - Distance sentence starts with speed 0.1 then distance since charge 0.01.
// - Momentary consumption is in 0.1 Wh per distance unit.
// - Last charge energy in Wh, from charger connect to disconnect.
// - Last discharge energy in Wh, from disconnect to reconnect.
// - Average discharge energy over the last 20 trips or fewer.
// - Largest single-trip discharge energy over the last 20 trips or fewer.
// - Last and current trip average consumption, energy over distance, 0.1.
// - Three remaining-distance estimates, each in 0.01 units.
// - A restore-defaults command resets configuration, statistics and log.
// - Pin field: bits 0-3 reserved, 4 mains, 5 ignition, 6 rapid charge.
`ifndef STATUS_SENTENCE_CONSTS_VH
`define STATUS_SENTENCE_CONSTS_VH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_ACTIVE_PERIOD 8'h04
`define REG_SLEEP_PERIOD 8'h08
`define REG_STATUS 8'h0c
`define REG_DROPS 8'h10

// Control bits
`define CTRL_FWD_BIT 0
`define CTRL_PERIODIC_BIT 1
`define CTRL_RESET 2'b11
`define ACTIVE_PERIOD_RESET 16'h03e8
`define SLEEP_PERIOD_RESET 16'h2710

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ----------------------------------------------------------------------
// Sentence kinds and tags
// ----------------------------------------------------------------------
`define KIND_CHARGER 3'd0
`define KIND_PACK 3'd1
`define KIND_DIST 3'd2
`define KIND_PINS 3'd3
`define KIND_CAN 3'd4
`define TAG_CHARGER 24'h435331
`define TAG_PACK 24'h435631
`define TAG_DIST 24'h445431
`define TAG_PINS 24'h494e31
`define TAG_CAN 24'h434e32

// Field widths in hex digits
`define NIB_BYTE 5'd2
`define NIB_WORD 5'd4
`define NIB_DWORD 5'd8
`define NIB_FLAG 5'd1
`define NIB_NONE 5'd0
`define LAST_CHARGER 4'd5
`define LAST_PACK 4'd9
`define LAST_DIST 4'd11
`define LAST_PINS 4'd3
`define LAST_CAN 4'd4
`define CAN_MAX_LEN 4'd8

// ASCII
`define ASC_COMMA 8'h2c
`define ASC_ZERO 8'h30
`define ASC_ALPHA 8'h37
`define ASC_LF 8'h0a

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_HZ 50000000
`define TICK_HZ 1000

`endif

/* sim/byte_sink.sv */
// Byte sink standing in for the serial bridge.
// Assumes the framer's valid/ready stream on aclk.
`timescale 1ns/100ps
`default_nettype none
module byte_sink (
    // Stream
    input wire logic aclk,
    input wire logic slow,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic tx_ready,
    // Capture
    output logic got,
    output logic [7:0] got_byte
);
    logic [1:0] cnt_ff = 2'h0;
    // Slow mode stalls three cycles in four to stress holding
    assign tx_ready = !slow || cnt_ff == 2'h0;
    always @(posedge aclk) begin
        cnt_ff <= cnt_ff + 2'h1;
        got <= tx_valid && tx_ready;
        got_byte <= tx_byte;
    end
endmodule // byte_sink
`default_nettype wire

/* sim/sentence_sva.sv */
// Checker for the framer's handshakes and pulses.
// Bound to the framer top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module sentence_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arready,
    input wire logic rvalid,
    // Commands
    input wire logic restore_req,
    input wire logic defaults_pulse,
    // Stream
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    input wire logic tx_ready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence stall_s; tx_valid && !tx_ready; endsequence
    tx_hold_a: assert property (stall_s |=> tx_valid && $stable(tx_byte))
        else $error("byte changed while stalled");
    tx_start_a: assert property ($rose(tx_valid) |-> tx_byte inside
        {8'h43, 8'h44, 8'h49}) else $error("sentence start not a tag");
    aw_pair_a: assert property (awready |-> wready && bvalid)
        else $error("write channels apart");
    ar_pair_a: assert property (arready |-> rvalid) else $error("read apart");
    aw_pulse_a: assert property (awready |=> !awready) else $error("awready");
    ar_pulse_a: assert property (arready |=> !arready) else $error("arready");
    dflt_a: assert property (restore_req |=> defaults_pulse)
        else $error("no defaults pulse");
    dflt_cause_a: assert property (defaults_pulse |-> $past(restore_req))
        else $error("stray defaults pulse");
endmodule // sentence_sva
`default_nettype wire

/* sim/status_sentence_port_test.sv */
// Bench for the status-sentence framer with a byte sink partner.
// Assumes the framer sources in hdl/ and the sink and checker in sim/.
`timescale 1ns/100ps
`default_nettype none
module status_sentence_port_test;
    logic aclk = 1'b0;
    logic aresetn;
    logic [7:0] awaddr, araddr, tx_byte, chg_count, chg_status, got_byte, cs;
    logic [31:0] wdata, rdata, can_tx_id, pack_voltage, d;
    logic [3:0] wstrb, can_tx_len;
    logic [1:0] bresp, rresp, can_tx_class, r;
    logic [2:0] req_kind;
    logic [15:0] chg_set_v, chg_set_i, chg_act_v, chg_act_i, pack_current;
    logic [63:0] can_tx_data;
    logic [383:0] dist_fields;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, req_valid, restore_req, defaults_pulse, sleep_mode;
    logic can_tx_valid, can_tx_ext, can_tx_rtr, chg_is_can, chg_act_v_ok;
    logic chg_act_i_ok, mains_presence_input, ignition_input;
    logic rapid_charge_input, tx_valid, tx_ready, slow, got;
    int err_count = 0, num_checks = 0, n, k;
    logic [7:0] sbuf [0:127];
    // Rows: cancharger, kind, length, tag, first field chars
    logic [63:0] rows [0:4] = '{64'h0100214353313341, 64'h00000f4353313341,
        64'h01013d4356313942, 64'h01026f4454313743, 64'h010313494e313330};
    status_sentence_port #(.MS_CYCLES(10)) uut (.*);
    byte_sink sink (.*);
    // Clock at 50 MHz
    always #10 aclk = !aclk;
    function logic [7:0] hexc(input logic [3:0] v);
        return v < 4'ha ? 8'h30 + v : 8'h37 + v;
    endfunction
    task chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    task close_out;
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Bus tasks sample and drive at the rising edge
    task wr(input logic [7:0] a, input logic [31:0] v);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
        do @(posedge aclk); while (bvalid !== 1'b1);
        {awvalid, wvalid, bready} <= 3'h0;
        @(posedge aclk);
    endtask
    task rd(input logic [7:0] a);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do @(posedge aclk); while (rvalid !== 1'b1);
        {d, r} = {rdata, rresp};
        {arvalid, rready} <= 2'h0;
        @(posedge aclk);
    endtask
    task take;
        n = 0;
        do begin
            @(negedge aclk);
            if (got === 1'b1) sbuf[n[6:0]] = got_byte;
            n += got;
        end while (!(got === 1'b1 && got_byte == 8'h0a));
        cs = 8'h00;
        for (k = 0; k < n - 3; k++) cs += sbuf[k];
        chk({sbuf[n-3], sbuf[n-2]}, {hexc(cs[7:4]), hexc(cs[3:0])});
        @(posedge aclk);
    endtask
    task pulse_can(input logic [1:0] c);
        {can_tx_class, can_tx_valid} <= {c, 1'b1};
        @(posedge aclk);
        can_tx_valid <= 1'b0;
    endtask
    task quiet;
        k = 0;
        repeat (30) @(negedge aclk) k += got;
        chk(k, 0);
        @(posedge aclk);
    endtask
    // Watchdog
    initial begin
        #800us;
        err_count++;
        close_out;
    end
    // Main sequence
    initial begin
        {awaddr, wdata, awvalid, wvalid, bready, araddr, arvalid,
            rready, req_valid, req_kind, restore_req, sleep_mode, slow,
            can_tx_valid, can_tx_ext, can_tx_rtr, can_tx_data} <= '0;
        {aresetn, wstrb, chg_count, pack_voltage} <= {5'h0f, 8'h3a, 32'h9b000000};
        {can_tx_class, can_tx_id, can_tx_len} <= {2'h0, 32'h18ff50e5, 4'h2};
        {chg_status, chg_set_v, chg_set_i, chg_act_v, chg_act_i} <= '1;
        {chg_is_can, chg_act_v_ok, chg_act_i_ok, pack_current} <= '1;
        {mains_presence_input, ignition_input, rapid_charge_input} <= 3'h6;
        dist_fields <= {368'h0, 16'h7c00};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00);
        chk(d, 32'h3);
        rd(8'h20);
        chk({d, r}, {32'h0, 2'h2});
        wr(8'h00, 32'h1);
        foreach (rows[i]) begin
            {chg_is_can, slow, req_kind, req_valid} <= {rows[i][56], i[0],
                rows[i][50:48], 1'b1};
            @(posedge aclk);
            req_valid <= 1'b0;
            take;
            chk(n, rows[i][47:40]);
            chk({sbuf[0], sbuf[1], sbuf[2]}, rows[i][39:16]);
            chk({sbuf[4], sbuf[5]}, rows[i][15:0]);
        end
        pulse_can(2'h0);
        quiet;
        pulse_can(2'h1);
        @(posedge aclk);
        pulse_can(2'h2);
        take;
        chk({n[7:0], sbuf[2], sbuf[4], sbuf[5]}, {8'h1b, 24'h323138});
        rd(8'h10);
        chk(d, 32'h1);
        wr(8'h00, 32'h0);
        pulse_can(2'h3);
        quiet;
        {restore_req, sleep_mode} <= 2'h3;
        @(posedge aclk);
        restore_req <= 1'b0;
        rd(8'h00);
        chk(d, 32'h3);
        wr(8'h04, 32'h2);
        quiet;
        sleep_mode <= 1'b0;
        take;
        chk({sbuf[0], sbuf[1]}, 16'h4353);
        close_out;
    end
endmodule // status_sentence_port_test
bind status_sentence_port sentence_sva chk_i (.*);
`default_nettype wire
